// ==== rtl/gtm_guard_timer.sv ====
`timescale 1ns/1ps
module gtm_guard_timer
  import gtm_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Low-speed oscillator level
  input wire logic i_lsclk,
  // Control register write
  input wire logic i_wr,
  input wire logic [7:0] i_wr_data,
  // Power mode and interrupt control
  input wire logic [2:0] i_pwr_mode,
  input wire logic i_tick_irq_enable,
  input wire logic i_tick_flag_clr,
  // Control register readback
  output logic [7:0] o_ctrl_rd,
  // Events
  output logic o_tick_irq_flag,
  output logic o_irq,
  output logic o_sys_reset,
  output logic o_reset_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic lsclk_r;
  logic ls_rise;
  logic ls_edge;
  logic [3:0] clr_code_r;
  logic en_r;
  logic mode_r;
  logic [1:0] int_r;
  logic [3:0] wr_clr;
  logic wr_en;
  logic wr_mode;
  logic [1:0] wr_int;
  logic wd_locked;
  logic deep;
  logic light;
  logic awake;
  logic start;
  logic timer_clr;
  logic wd_clear;
  logic cnt_clr;
  logic cnt_inc;
  logic expire;
  logic [15:0] term;
  gtm_clr_state_type clr_state_r;
  gtm_clr_state_type clr_state_nxt;
  logic tick_flag_r;
  logic tick_flag_nxt;
  logic irq_r;
  logic sys_reset_r;
  logic pending_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign wr_clr = i_wr_data[GTM_CLR_MSB:GTM_CLR_LSB];
  assign wr_en = i_wr_data[GTM_EN_BIT];
  assign wr_mode = i_wr_data[GTM_MODE_BIT];
  assign wr_int = i_wr_data[GTM_INT_MSB:GTM_INT_LSB];

  assign deep = (i_pwr_mode == GTM_PM_DEEP) ||
                (i_pwr_mode == GTM_PM_DEEPEST);
  assign light = (i_pwr_mode == GTM_PM_LIGHT);
  assign awake = (i_pwr_mode == GTM_PM_ACTIVE) ||
                 (i_pwr_mode == GTM_PM_IDLE);

  assign wd_locked = en_r && (mode_r == GTM_MODE_WATCHDOG);

  ////////////////////////////////////////////////////////////////////////////
  // Slow oscillator edges

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lsclk_r <= 1'b0;
    end else begin
      lsclk_r <= i_lsclk;
    end
  end

  assign ls_rise = i_lsclk && !lsclk_r;
  // Either edge closes a half-period clear window
  assign ls_edge = i_lsclk ^ lsclk_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_r <= GTM_EN_RST;
    end else if (i_wr) begin
      if (wr_en) begin
        en_r <= 1'b1;
      end else if (!wd_locked) begin
        en_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_r <= GTM_MODE_RST;
    end else if (i_wr && !wd_locked) begin
      mode_r <= wr_mode;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_r <= GTM_INT_RST;
    end else if (i_wr) begin
      int_r <= wr_int;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clr_code_r <= GTM_CLR_RST;
    end else if (i_wr && en_r) begin
      clr_code_r <= wr_clr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear sequence

  always_comb begin
    clr_state_nxt = clr_state_r;
    wd_clear = 1'b0;
    unique case (clr_state_r)
      GTM_CLR_IDLE: begin
        if (i_wr && wd_locked && wr_clr == GTM_CLR_ARM) begin
          clr_state_nxt = GTM_CLR_ARMED;
        end
      end
      GTM_CLR_ARMED: begin
        if (i_wr && wd_locked) begin
          if (wr_clr == GTM_CLR_FIRE) begin
            wd_clear = 1'b1;
            clr_state_nxt = GTM_CLR_IDLE;
          end else if (wr_clr != GTM_CLR_ARM) begin
            clr_state_nxt = GTM_CLR_IDLE;
          end
        end else if (ls_edge) begin
          clr_state_nxt = GTM_CLR_IDLE;
        end
      end
      default: begin
        clr_state_nxt = GTM_CLR_IDLE;
      end
    endcase
    if (deep) begin
      clr_state_nxt = GTM_CLR_IDLE;
      wd_clear = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clr_state_r <= GTM_CLR_IDLE;
    end else begin
      clr_state_r <= clr_state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  always_comb begin
    unique case (int_r)
      2'h0: term = GTM_TERM_0;
      2'h1: term = GTM_TERM_1;
      2'h2: term = GTM_TERM_2;
      2'h3: term = GTM_TERM_3;
    endcase
  end

  assign start = i_wr && wr_en && !en_r;
  assign timer_clr = i_wr && en_r && (mode_r == GTM_MODE_TIMER) &&
                     wr_clr[0];
  assign cnt_clr = deep || start || timer_clr || wd_clear;
  assign cnt_inc = en_r && !deep && ls_rise;

  gtm_counter #(
    .WIDTH(GTM_CNT_W)
  ) u_counter (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clr(cnt_clr),
    .i_inc(cnt_inc),
    .i_term(term),
    .o_expire(expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog reset

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pending_r <= 1'b0;
    end else if (expire && mode_r == GTM_MODE_WATCHDOG && light) begin
      pending_r <= 1'b1;
    end else if (wd_clear || deep) begin
      pending_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sys_reset_r <= 1'b0;
    end else if (mode_r == GTM_MODE_WATCHDOG) begin
      if (expire && awake) begin
        sys_reset_r <= 1'b1;
      end else if (pending_r && awake) begin
        sys_reset_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick flag and interrupt

  always_comb begin
    tick_flag_nxt = tick_flag_r;
    if (i_tick_flag_clr) begin
      tick_flag_nxt = 1'b0;
    end
    if (expire && mode_r == GTM_MODE_TIMER) begin
      tick_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_flag_r <= 1'b0;
    end else begin
      tick_flag_r <= tick_flag_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= tick_flag_nxt && i_tick_irq_enable &&
               (mode_r == GTM_MODE_TIMER);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_ctrl_rd = {clr_code_r, en_r, mode_r, int_r};
  assign o_tick_irq_flag = tick_flag_r;
  assign o_irq = irq_r;
  assign o_sys_reset = sys_reset_r;
  assign o_reset_pending = pending_r;

endmodule // gtm_guard_timer

// ==== inc/gtm_pkg.sv ====
package gtm_pkg;

  // Counter width
  localparam int GTM_CNT_W = 15;

  // Control byte field positions
  localparam int GTM_CLR_MSB = 7;
  localparam int GTM_CLR_LSB = 4;
  localparam int GTM_EN_BIT = 3;
  localparam int GTM_MODE_BIT = 2;
  localparam int GTM_INT_MSB = 1;
  localparam int GTM_INT_LSB = 0;

  // Control reset values
  localparam logic [3:0] GTM_CLR_RST = 4'h0;
  localparam logic GTM_EN_RST = 1'b0;
  localparam logic GTM_MODE_RST = 1'b0;
  localparam logic [1:0] GTM_INT_RST = 2'h0;

  // Mode bit values
  localparam logic GTM_MODE_WATCHDOG = 1'b0;
  localparam logic GTM_MODE_TIMER = 1'b1;

  // Clear sequence codes
  localparam logic [3:0] GTM_CLR_ARM = 4'hA;
  localparam logic [3:0] GTM_CLR_FIRE = 4'h5;

  // Terminal counts, one per interval select value
  localparam logic [15:0] GTM_TERM_0 = 16'h0040;
  localparam logic [15:0] GTM_TERM_1 = 16'h0200;
  localparam logic [15:0] GTM_TERM_2 = 16'h2000;
  localparam logic [15:0] GTM_TERM_3 = 16'h8000;

  // Power mode codes on i_pwr_mode
  localparam logic [2:0] GTM_PM_ACTIVE = 3'h0;
  localparam logic [2:0] GTM_PM_IDLE = 3'h1;
  localparam logic [2:0] GTM_PM_LIGHT = 3'h2;
  localparam logic [2:0] GTM_PM_DEEP = 3'h3;
  localparam logic [2:0] GTM_PM_DEEPEST = 3'h4;

  // Clear sequence states
  typedef enum logic [1:0] {
    GTM_CLR_IDLE = 2'b01,
    GTM_CLR_ARMED = 2'b10
  } gtm_clr_state_type;

endpackage

// ==== rtl/gtm_counter.sv ====
`timescale 1ns/1ps
module gtm_counter
  import gtm_pkg::*;
#(
  parameter int WIDTH = GTM_CNT_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Control
  input wire logic i_clr,
  input wire logic i_inc,
  input wire logic [WIDTH:0] i_term,
  // Status
  output logic o_expire
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH:0] count_inc;

  assign count_inc = {1'b0, count_r} + {{WIDTH{1'b0}}, 1'b1};

  // Interval reached on this increment
  assign o_expire = i_inc && !i_clr && (count_inc == i_term);

  ////////////////////////////////////////////////////////////////////////////
  // Count, clear wins over increment, wrap at the terminal count

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_r <= '0;
    end else if (i_clr) begin
      count_r <= '0;
    end else if (o_expire) begin
      count_r <= '0;
    end else if (i_inc) begin
      count_r <= count_inc[WIDTH-1:0];
    end
  end

endmodule // gtm_counter

// ==== dv/gtm_guard_timer_props.sv ====
`timescale 1ns/1ps
module gtm_guard_timer_props
  import gtm_pkg::*;
(
  // Clock, reset and inputs
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_lsclk,
  input wire logic i_wr,
  input wire logic [7:0] i_wr_data,
  input wire logic [2:0] i_pwr_mode,
  input wire logic i_tick_irq_enable,
  input wire logic i_tick_flag_clr,
  // Outputs watched
  input wire logic [7:0] o_ctrl_rd,
  input wire logic o_tick_irq_flag,
  input wire logic o_irq,
  input wire logic o_sys_reset,
  input wire logic o_reset_pending
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_reset_idle: assert property ($rose(i_reset_n) |->
    o_ctrl_rd == 8'h00 && !o_sys_reset) else $error("not idle after reset");
  a_sys_hold: assert property (o_sys_reset |=> o_sys_reset)
    else $error("system reset dropped");
  a_rst_enabled: assert property ($rose(o_sys_reset) |->
    $past(o_ctrl_rd[3])) else $error("reset while disabled");
  a_timer_no_rst: assert property ($rose(o_sys_reset) |->
    $past(o_ctrl_rd[2]) == GTM_MODE_WATCHDOG) else $error("timer reset");
  a_wd_no_flag: assert property ($rose(o_tick_irq_flag) |->
    $past(o_ctrl_rd[2]) == GTM_MODE_TIMER) else $error("flag in watchdog");
  a_wd_locked: assert property (o_ctrl_rd[3] && !o_ctrl_rd[2] |=>
    o_ctrl_rd[3] && !o_ctrl_rd[2]) else $error("watchdog unlocked");
  a_int_taken: assert property (i_wr |=>
    o_ctrl_rd[1:0] == $past(i_wr_data[1:0])) else $error("interval lost");
  a_clr_ignored: assert property (i_wr && !o_ctrl_rd[3] &&
    !i_wr_data[3] |=> $stable(o_ctrl_rd[7:4])) else $error("code stored");
  a_flag_sticky: assert property (o_tick_irq_flag &&
    !i_tick_flag_clr |=> o_tick_irq_flag) else $error("flag dropped");
  a_irq_gate: assert property (!i_tick_irq_enable &&
    !$past(i_tick_irq_enable) |-> !o_irq) else $error("irq not gated");
  a_light_quiet: assert property (i_pwr_mode == GTM_PM_LIGHT &&
    $past(i_pwr_mode) == GTM_PM_LIGHT |-> !$rose(o_sys_reset))
    else $error("reset in light sleep");
  a_wake_reset: assert property (o_reset_pending && !i_wr &&
    i_pwr_mode == GTM_PM_ACTIVE |-> ##[1:2] o_sys_reset)
    else $error("no reset on wake");
  a_deep_clear: assert property (i_pwr_mode == GTM_PM_DEEP &&
    $past(i_pwr_mode) == GTM_PM_DEEP |-> !o_reset_pending)
    else $error("pending in deep sleep");

  c_reset: cover property ($rose(o_sys_reset));
  c_irq: cover property ($rose(o_irq));
  c_pending: cover property ($rose(o_reset_pending));
endmodule // gtm_guard_timer_props

bind gtm_guard_timer gtm_guard_timer_props u_props (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_lsclk(i_lsclk), .i_wr(i_wr),
  .i_wr_data(i_wr_data), .i_pwr_mode(i_pwr_mode),
  .i_tick_irq_enable(i_tick_irq_enable), .i_tick_flag_clr(i_tick_flag_clr),
  .o_ctrl_rd(o_ctrl_rd), .o_tick_irq_flag(o_tick_irq_flag), .o_irq(o_irq),
  .o_sys_reset(o_sys_reset), .o_reset_pending(o_reset_pending));

// ==== dv/gtm_guard_timer_tb_top.sv ====
`timescale 1ns/1ps
module gtm_guard_timer_tb_top
  import gtm_pkg::*;
;
  logic i_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic i_lsclk = 1'h0;
  logic i_wr = 1'h0;
  logic [7:0] i_wr_data = 8'h00;
  logic [2:0] i_pwr_mode = GTM_PM_ACTIVE;
  logic i_tick_irq_enable = 1'h0;
  logic i_tick_flag_clr = 1'h0;
  logic [7:0] o_ctrl_rd;
  logic o_tick_irq_flag;
  logic o_irq;
  logic o_sys_reset;
  logic o_reset_pending;
  int err_count = 0;
  int n_checks = 0;
  logic [15:0] term;

  always #20 i_clk = ~i_clk;

  gtm_guard_timer DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_lsclk(i_lsclk), .i_wr(i_wr), .i_wr_data(i_wr_data),
    .i_pwr_mode(i_pwr_mode), .i_tick_irq_enable(i_tick_irq_enable),
    .i_tick_flag_clr(i_tick_flag_clr), .o_ctrl_rd(o_ctrl_rd),
    .o_tick_irq_flag(o_tick_irq_flag), .o_irq(o_irq),
    .o_sys_reset(o_sys_reset), .o_reset_pending(o_reset_pending));

  ////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Slow clock stays low between rises so writes fit inside one phase
  task automatic rise(input int n);
    repeat (n) begin
      i_lsclk = 1'h1;
      step(1);
      i_lsclk = 1'h0;
      step(1);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    step(1);
    i_wr = 1'h1;
    i_wr_data = d;
    step(1);
    i_wr = 1'h0;
  endtask

  task automatic restart();
    i_reset_n = 1'h0;
    i_pwr_mode = GTM_PM_ACTIVE;
    step(4);
    i_reset_n = 1'h1;
  endtask

  task automatic clr_flag();
    i_tick_flag_clr = 1'h1;
    step(1);
    i_tick_flag_clr = 1'h0;
    step(1);
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s is %b, expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: ctrl is %h, expected %h", $time, got, exp);
    end
  endtask

  // Event must stay low one rise short of n and be high at rise n
  task automatic expect_at(input int n, input logic tmr);
    rise(n - 1);
    chk1(tmr ? o_tick_irq_flag : o_sys_reset, 1'h0, "early event");
    rise(1);
    chk1(tmr ? o_tick_irq_flag : o_sys_reset, 1'h1, "missing event");
  endtask

  task automatic give_verdict();
    $display("Checks: %0d, errors: %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    restart();
    wr(8'hA0);
    wr(8'h50);
    chk8(o_ctrl_rd, 8'h00);
    rise(70);
    chk1(o_sys_reset, 1'h0, "reset");
    for (int i = 0; i < 4; i++) begin
      term = (i == 0) ? GTM_TERM_0 : (i == 1) ? GTM_TERM_1 :
             (i == 2) ? GTM_TERM_2 : GTM_TERM_3;
      restart();
      i_pwr_mode = (i == 1) ? GTM_PM_IDLE : GTM_PM_ACTIVE;
      wr({6'h02, i[1:0]});
      expect_at(int'(term), 1'h0);
      chk1(o_tick_irq_flag, 1'h0, "flag");
    end
    // Mode and disable refused, interval taken, then a clear
    restart();
    wr(8'h08);
    rise(60);
    wr(8'h05);
    chk8(o_ctrl_rd, 8'h09);
    wr(8'hA9);
    wr(8'h59);
    expect_at(512, 1'h0);
    // Wrong code, then a slow edge inside the window
    restart();
    wr(8'h08);
    rise(59);
    wr(8'hA8);
    wr(8'h38);
    wr(8'h58);
    rise(1);
    wr(8'hA8);
    rise(1);
    wr(8'h58);
    expect_at(3, 1'h0);
    // Timer mode
    restart();
    wr(8'h0C);
    expect_at(64, 1'h1);
    chk1(o_irq, 1'h0, "irq");
    i_tick_irq_enable = 1'h1;
    step(2);
    chk1(o_irq, 1'h1, "irq");
    clr_flag();
    step(1);
    chk1(o_tick_irq_flag, 1'h0, "flag");
    rise(30);
    wr(8'h1C);
    expect_at(64, 1'h1);
    clr_flag();
    rise(30);
    wr(8'h04);
    rise(100);
    chk1(o_tick_irq_flag, 1'h0, "flag");
    wr(8'h0C);
    expect_at(64, 1'h1);
    chk1(o_sys_reset, 1'h0, "reset");
    // Power modes
    restart();
    wr(8'h08);
    i_pwr_mode = GTM_PM_LIGHT;
    rise(64);
    chk1(o_sys_reset, 1'h0, "reset");
    chk1(o_reset_pending, 1'h1, "pending");
    i_pwr_mode = GTM_PM_ACTIVE;
    step(3);
    chk1(o_sys_reset, 1'h1, "reset");
    for (int j = 0; j < 2; j++) begin
      restart();
      wr(8'h08);
      i_pwr_mode = GTM_PM_LIGHT;
      rise(104);
      chk1(o_reset_pending, 1'h1, "pending");
      i_pwr_mode = (j == 1) ? GTM_PM_DEEPEST : GTM_PM_DEEP;
      rise(30);
      chk1(o_reset_pending, 1'h0, "pending");
      chk1(o_sys_reset, 1'h0, "reset");
      chk8(o_ctrl_rd, 8'h08);
      i_pwr_mode = GTM_PM_ACTIVE;
      expect_at(64, 1'h0);
    end
    give_verdict();
  end
endmodule // gtm_guard_timer_tb_top
